// ### bax_pkg.sv
// Package of constants and types for the barrier auxiliary outputs
// How it works
// - Ticket activation holds the interlock active
// - Interlock releases when barrier reaches closed
// - Interlock on: activate on trigger contact opening
// - Interlock off: activate on trigger contact closing
// - Each feature drives only its selected output
// - Closed polarity: output closed while interlock active
// - Open polarity: output open while interlock active
// - Light enable independent, off after reset
// - Four light profiles selectable
// - Hold profile: on from activation through motion
// - Hold profile: on for courtesy time, then off
// - Motion profile: on only while moving
// - Flashing profile: flash during motion and pre-delay
// - Steady profile: flashing conditions, but steady on
// - Courtesy phase starts after motorised stop only
// - Courtesy time four seconds to 9h59m59s
package bax_pkg;
    // Clock and time figures
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SEC_NS          = 1_000_000_000;
    localparam int SEC_CYC         = SEC_NS / CLK_PERIOD_NS;
    localparam int FLASH_PERIOD_MS = 1000;
    localparam int FLASH_HALF_CYC  =
        (FLASH_PERIOD_MS * 1_000_000 / 2) / CLK_PERIOD_NS;
    // Courtesy time range in seconds
    localparam logic [15:0] HOLD_MIN_S = 16'h0004;
    localparam logic [15:0] HOLD_MAX_S = 16'h8c9f;
    localparam logic [15:0] HOLD_RST_S = 16'h003c;
    // Register byte addresses
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  CTRL_ADDR  = 8'h00;
    localparam logic [7:0]  HOLD_ADDR  = 8'h04;
    localparam logic [7:0]  STAT_ADDR  = 8'h08;
    // Control register width and reset value
    localparam int          CTRL_W     = 11;
    localparam logic [10:0] CTRL_RST   = 11'h000;
    // Status field positions
    localparam int          ST_IL_BIT   = 0;
    localparam int          ST_LI_BIT   = 1;
    localparam int          ST_BUSY_BIT = 2;
    localparam int          ST_LINE_BIT = 3;
    localparam int          ST_SECS_LSB = 16;
    // Number of physical outputs
    localparam int          NUM_PHYS    = 5;

    // Output route codes
    typedef enum logic [2:0] {
        RT_OFF     = 3'b000,
        RT_RELAY   = 3'b001,
        RT_BIDIR   = 3'b010,
        RT_AUX     = 3'b011,
        RT_LAMP    = 3'b100,
        RT_SOUNDER = 3'b101
    } bax_route_type;

    // Light profiles
    typedef enum logic [1:0] {
        PR_HOLD   = 2'b00,
        PR_MOTION = 2'b01,
        PR_FLASH  = 2'b10,
        PR_STEADY = 2'b11
    } bax_profile_type;

    // Interlock states
    typedef enum logic {
        IL_FREE = 1'b0,
        IL_HELD = 1'b1
    } bax_il_type;

    // Control register layout
    typedef struct packed {
        bax_profile_type profile;
        bax_route_type   light_route;
        logic            light_en;
        logic            ti_open_pol;
        bax_route_type   ti_route;
        logic            ti_en;
    } bax_ctrl_type;

    // Barrier condition from motor control
    typedef struct packed {
        logic moving;
        logic motorised;
        logic pre_delay;
        logic closed;
    } bax_barrier_type;

    // Physical outputs, bit index plus one is the route code
    typedef struct packed {
        logic sounder;
        logic lamp;
        logic aux;
        logic bidir;
        logic relay;
    } bax_phys_type;
endpackage : bax_pkg

// ### bax_hold_timer.sv
// Courtesy hold timer counting whole seconds
`timescale 1ns/1ps
module bax_hold_timer
    import bax_pkg::*;
#(
    parameter int SEC_CYC_P = SEC_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,   // Load and start
    input  wire logic [15:0] secs_i,    // Seconds to hold
    output logic             busy_o,    // Hold running
    output logic [15:0]      secs_o     // Seconds left
);
    logic [27:0] div_q;                 // Cycles within a second
    logic [27:0] div_d;
    logic [15:0] sec_q;                 // Seconds remaining
    logic [15:0] sec_d;
    logic        tick;                  // One-second enable

    assign tick = (div_q == 28'(SEC_CYC_P - 1));

    // Next count
    always_comb begin
        div_d = div_q;
        sec_d = sec_q;
        if (start_i) begin
            // Restart from the full hold time
            div_d = '0;
            sec_d = secs_i;
        end else if (sec_q != 16'h0000) begin
            if (tick) begin
                div_d = '0;
                sec_d = sec_q - 16'h0001;
            end else begin
                div_d = div_q + 28'h0000001;
            end
        end
    end

    // Count registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
            sec_q <= '0;
        end else begin
            div_q <= div_d;
            sec_q <= sec_d;
        end
    end

    assign busy_o = (sec_q != 16'h0000);
    assign secs_o = sec_q;
endmodule : bax_hold_timer

// ### bax_aux_out.sv
// Ticket interlock and courtesy light outputs with APB registers
`timescale 1ns/1ps
module bax_aux_out
    import bax_pkg::*;
#(
    parameter int SEC_CYC_P   = SEC_CYC,
    parameter int FLASH_CYC_P = FLASH_HALF_CYC
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              pulse_trig_i,  // Contact closed
    input  wire bax_barrier_type   barrier_i,     // Barrier condition
    input  wire logic              aux_line_i,    // Bidir line level
    output logic                   activate_o,    // Activation pulse
    output bax_phys_type           phys_o,        // Outputs asserted
    output logic                   aux_line_o,    // Bidir line value
    output logic                   aux_line_oe_o  // Bidir line sink
);
    // Register state
    bax_ctrl_type cfg_q;               // Control register
    bax_ctrl_type cfg_d;
    logic [15:0]  hold_q;              // Courtesy time in seconds
    logic [15:0]  hold_d;
    logic [31:0]  prdata_q;            // Read data
    logic [31:0]  prdata_d;
    logic         slverr_q;            // Unmapped address
    logic         slverr_d;
    // Trigger and interlock state
    logic         trig_q;              // Previous trigger level
    logic         closed_q;            // Previous closed level
    logic         act_q;               // Activation pulse
    logic         act_d;
    bax_il_type   il_q;                // Interlock state
    bax_il_type   il_d;
    // Light state
    logic         mot_q;               // Motorised motion last cycle
    logic         mot;
    logic         stop_evt;            // Motorised motion ended
    logic         actl_q;              // Activation awaiting motion
    logic         actl_d;
    logic [27:0]  fl_cnt_q;            // Flash half-period count
    logic [27:0]  fl_cnt_d;
    logic         flash_q;             // Flash phase
    logic         flash_d;
    logic         warn;                // Motion or pre-delay
    logic         prof_on;             // Profile wants light
    logic         light_q;             // Light state
    logic         light_d;
    logic         busy;                // Courtesy phase running
    logic [15:0]  secs_left;           // Courtesy seconds left
    // Output routing
    logic [NUM_PHYS-1:0] phys_d;
    bax_phys_type        phys_q;
    logic [NUM_PHYS-1:0] route_mask;   // Outputs any feature selects
    logic         il_level;            // Interlock after polarity
    // Bus decode
    logic         setup;
    logic         wr_en;

    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pwrite_i;

    // Register writes and registered read answer
    always_comb begin
        cfg_d    = cfg_q;
        hold_d   = hold_q;
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (wr_en && !slverr_q) begin
            if (paddr_i == CTRL_ADDR) begin
                cfg_d = bax_ctrl_type'(pwdata_i[CTRL_W-1:0]);
            end else if (paddr_i == HOLD_ADDR) begin
                // Keep the courtesy time inside its range
                if (pwdata_i[31:16] != 16'h0000 ||
                    pwdata_i[15:0] > HOLD_MAX_S) begin
                    hold_d = HOLD_MAX_S;
                end else if (pwdata_i[15:0] < HOLD_MIN_S) begin
                    hold_d = HOLD_MIN_S;
                end else begin
                    hold_d = pwdata_i[15:0];
                end
            end
        end
        if (setup) begin
            // Capture read data during the setup cycle
            prdata_d = '0;
            slverr_d = 1'b0;
            case (paddr_i)
                CTRL_ADDR: prdata_d[CTRL_W-1:0] = cfg_q;
                HOLD_ADDR: prdata_d[15:0] = hold_q;
                STAT_ADDR: begin
                    prdata_d[ST_IL_BIT]   = (il_q == IL_HELD);
                    prdata_d[ST_LI_BIT]   = light_q;
                    prdata_d[ST_BUSY_BIT] = busy;
                    prdata_d[ST_LINE_BIT] = aux_line_i;
                    prdata_d[ST_SECS_LSB +: 16] = secs_left;
                end
                default: slverr_d = 1'b1;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_q    <= bax_ctrl_type'(CTRL_RST);
            hold_q   <= HOLD_RST_S;
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else begin
            cfg_q    <= cfg_d;
            hold_q   <= hold_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_q;
    assign pslverr_o = slverr_q & psel_i & penable_i;

    // Trigger edge select and interlock next state
    always_comb begin
        if (cfg_q.ti_en) begin
            act_d = trig_q & ~pulse_trig_i;
        end else begin
            act_d = ~trig_q & pulse_trig_i;
        end
        il_d = il_q;
        case (il_q)
            IL_FREE: begin
                // A ticket activation locks further tickets
                if (cfg_q.ti_en && act_q) begin
                    il_d = IL_HELD;
                end
            end
            IL_HELD: begin
                if (!cfg_q.ti_en) begin
                    il_d = IL_FREE;
                end else if (act_q) begin
                    il_d = IL_HELD;
                end else if (barrier_i.closed && !closed_q) begin
                    il_d = IL_FREE;
                end
            end
            default: il_d = IL_FREE;
        endcase
    end

    // Trigger and interlock flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            trig_q   <= 1'b0;
            closed_q <= 1'b0;
            act_q    <= 1'b0;
            il_q     <= IL_FREE;
        end else begin
            trig_q   <= pulse_trig_i;
            closed_q <= barrier_i.closed;
            act_q    <= act_d;
            il_q     <= il_d;
        end
    end

    assign activate_o = act_q;

    // Courtesy phase timer, started when motorised motion stops
    bax_hold_timer #(
        .SEC_CYC_P (SEC_CYC_P)
    ) u_hold (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (stop_evt),
        .secs_i    (hold_q),
        .busy_o    (busy),
        .secs_o    (secs_left)
    );

    assign mot      = barrier_i.moving & barrier_i.motorised;
    assign stop_evt = mot_q & ~mot;
    assign warn     = barrier_i.moving | barrier_i.pre_delay;

    // Light profile, flash divider and activation latch
    always_comb begin
        // Latch activation until motion or the courtesy phase begins
        actl_d = (actl_q | act_q) & ~barrier_i.moving & ~stop_evt;
        fl_cnt_d = fl_cnt_q;
        flash_d  = flash_q;
        if (!warn) begin
            // Each warning begins in the lit half
            fl_cnt_d = '0;
            flash_d  = 1'b1;
        end else if (fl_cnt_q == 28'(FLASH_CYC_P - 1)) begin
            fl_cnt_d = '0;
            flash_d  = ~flash_q;
        end else begin
            fl_cnt_d = fl_cnt_q + 28'h0000001;
        end
        // The stop cycle keeps the light up until the timer shows busy
        case (cfg_q.profile)
            PR_HOLD:   prof_on = actl_q | act_q | warn | busy
                                 | stop_evt;
            PR_MOTION: prof_on = barrier_i.moving;
            PR_FLASH:  prof_on = warn & flash_q;
            PR_STEADY: prof_on = warn;
            default:   prof_on = 1'b0;
        endcase
        light_d = cfg_q.light_en & prof_on;
    end

    // Light flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mot_q    <= 1'b0;
            actl_q   <= 1'b0;
            fl_cnt_q <= '0;
            flash_q  <= 1'b1;
            light_q  <= 1'b0;
        end else begin
            mot_q    <= mot;
            actl_q   <= actl_d;
            fl_cnt_q <= fl_cnt_d;
            flash_q  <= flash_d;
            light_q  <= light_d;
        end
    end

    // Polarity acts on the routed output, so open sense inverts it
    assign il_level = (il_q == IL_HELD) ^ cfg_q.ti_open_pol;

    // Route each feature to the output whose code it selects
    for (genvar g = 0; g < NUM_PHYS; g++) begin : g_route
        logic ti_sel;
        logic li_sel;
        assign ti_sel = (cfg_q.ti_route == bax_route_type'(3'(g + 1)));
        assign li_sel = (cfg_q.light_route == bax_route_type'(3'(g + 1)));
        assign phys_d[g] = (ti_sel & il_level) | (li_sel & light_q);
        assign route_mask[g] = ti_sel | li_sel;
    end

    // Output flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phys_q <= '0;
        end else begin
            phys_q <= bax_phys_type'(phys_d);
        end
    end

    assign phys_o        = phys_q;
    assign aux_line_o    = 1'b0;           // Line is only ever sunk
    assign aux_line_oe_o = phys_q.bidir;

    // Checks
    AST_IL_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (act_q && cfg_q.ti_en) |=> (il_q == IL_HELD))
        else $error("interlock not held after activation");
    AST_IL_FREE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (barrier_i.closed && !closed_q && !act_q) |=> (il_q == IL_FREE))
        else $error("interlock not released at closed");
    AST_TRIG_OPEN: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (cfg_q.ti_en && trig_q && !pulse_trig_i) |=> activate_o)
        else $error("no activation on contact opening");
    AST_TRIG_CLOSE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (!cfg_q.ti_en && !trig_q && pulse_trig_i) |=> activate_o)
        else $error("no activation on contact closing");
    AST_ROUTE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 ((phys_o & ~$past(route_mask)) == '0))
        else $error("unselected output asserted");
    AST_POL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (il_q == IL_HELD && cfg_q.ti_route == RT_RELAY &&
         cfg_q.light_route != RT_RELAY)
        |=> (phys_o.relay == !$past(cfg_q.ti_open_pol)))
        else $error("interlock polarity wrong on relay");
    AST_LIGHT_EN: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        !cfg_q.light_en |=> !light_q)
        else $error("light on while disabled");
    AST_MOTION: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg_q.profile == PR_MOTION && !barrier_i.moving) |=> !light_q)
        else $error("motion profile lit while stationary");
    AST_STEADY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg_q.light_en && cfg_q.profile == PR_STEADY && warn)
        |=> light_q)
        else $error("steady profile not lit");
    AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg_q.light_en && cfg_q.profile == PR_HOLD && stop_evt)
        |=> light_q ##1 (light_q && busy))
        else $error("courtesy phase not lit after stop");
    CV_IL: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (il_q == IL_HELD) ##[1:50] (il_q == IL_FREE));
    CV_FLASH: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg_q.profile == PR_FLASH && light_q) ##1 !light_q);
    CV_HOLD_END: cover property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) busy ##1 !busy);
    CV_WRITE: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_en && paddr_i == CTRL_ADDR);
endmodule : bax_aux_out

// ### bax_tvm_model.sv
// Ticket vending machine and pulled-up aux line at the far side
`timescale 1ns/1ps
module bax_tvm_model (
    input  wire logic       ref_clk_i,
    input  wire logic       vend_i,      // Issue one ticket
    input  wire logic [7:0] close_len_i, // Cycles the contact stays shut
    input  wire logic       line_oe_i,   // Device sinks the aux line
    output logic            trig_o,      // Contact shut to common return
    output logic            line_o       // Resolved aux line level
);
    logic [7:0] cnt_q = 8'h00; // Shut cycles left

    // Floating terminal pulls high unless the device sinks it
    assign line_o = line_oe_i ? 1'b0 : 1'b1;

    // Contact shuts on a vend request and opens after the set length
    initial trig_o = 1'b0;
    always @(posedge ref_clk_i) begin
        if (cnt_q != 8'h00) begin
            cnt_q  <= cnt_q - 8'h01;
            trig_o <= (cnt_q != 8'h01);
        end else if (vend_i) begin
            cnt_q  <= close_len_i;
            trig_o <= 1'b1;
        end
    end
endmodule : bax_tvm_model

// ### test_barrier_aux_output_logic.sv
// Self-checking bench for the barrier auxiliary outputs
`timescale 1ns/1ps
module test_barrier_aux_output_logic;
    import bax_pkg::*;
    typedef struct {
        logic [2:0] rt;   // Interlock route code
        logic       pol;  // Open polarity
        logic [4:0] held; // Outputs while locked
        logic [4:0] free; // Outputs once released
    } bax_row_type;

    localparam int TMO = 20000; // Cycle ceiling of the whole run
    logic            clk = 1'b0, rst_n = 1'b0;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    logic            pready, pslverr, er, trig, aux_in, act, oe, aux_o;
    logic            vend = 1'b0;
    logic [7:0]      clen = 8'h03;
    bax_barrier_type barrier = 4'b0001;
    bax_phys_type    phys;
    int              errors = 0, cmp_count = 0, act_cnt = 0, cyc = 0;
    int              n, h;
    bax_row_type rows [9] = '{
        '{3'h0, 1'b0, 5'h00, 5'h00}, '{3'h1, 1'b0, 5'h01, 5'h00},
        '{3'h2, 1'b0, 5'h02, 5'h00}, '{3'h3, 1'b0, 5'h04, 5'h00},
        '{3'h4, 1'b0, 5'h08, 5'h00}, '{3'h5, 1'b0, 5'h10, 5'h00},
        '{3'h1, 1'b1, 5'h00, 5'h01}, '{3'h2, 1'b1, 5'h00, 5'h02},
        '{3'h6, 1'b1, 5'h00, 5'h00}};
    logic [31:0] hw [4] = '{32'h2, 32'h10000, 32'h8ca0, 32'h4};
    logic [31:0] hx [4] = '{32'h4, 32'h8c9f, 32'h8c9f, 32'h4};

    bax_aux_out #(.SEC_CYC_P(20), .FLASH_CYC_P(4)) dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pulse_trig_i(trig), .barrier_i(barrier),
        .aux_line_i(aux_in), .activate_o(act), .phys_o(phys),
        .aux_line_o(aux_o), .aux_line_oe_o(oe));

    bax_tvm_model tvm (
        .ref_clk_i(clk), .vend_i(vend), .close_len_i(clen),
        .line_oe_i(oe), .trig_o(trig), .line_o(aux_in));

    // Clock at 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    // Activation pulse counter and hang guard
    always @(posedge clk) begin
        if (act === 1'b1) act_cnt <= act_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            errors++;
            results();
        end
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask : idle

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cw(input logic te, input logic [2:0] tr,
        input logic op, input logic le, input bax_route_type lr,
        input bax_profile_type pf);
        bax_ctrl_type c;
        c = '{profile: pf, light_route: lr, light_en: le, ti_open_pol: op,
              ti_route: bax_route_type'(tr), ti_en: te};
        return 32'(c);
    endfunction : cw

    task automatic bar(input logic [3:0] b);
        @(posedge clk);
        barrier <= bax_barrier_type'(b);
    endtask : bar

    task automatic ticket(input logic [7:0] len);
        @(posedge clk);
        clen <= len; vend <= 1'b1;
        @(posedge clk);
        vend <= 1'b0;
    endtask : ticket

    // Set a light profile, move the barrier, look at the lamp
    task automatic lt(input bax_profile_type pf, input logic le,
                      input logic [3:0] b, input logic e);
        apb(1'b1, CTRL_ADDR, cw(1'b0, 3'h0, 1'b0, le, RT_LAMP, pf));
        bar(b);
        idle(5);
        chk(32'(phys.lamp), 32'(e));
    endtask : lt

    // Main sequence
    initial begin
        idle(10);
        rst_n <= 1'b1;
        idle(1);
        chk(32'(phys), 32'h0);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'(CTRL_RST));
        apb(1'b0, HOLD_ADDR, 32'h0);
        chk(rd, 32'(HOLD_RST_S));
        apb(1'b0, 8'h0c, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        // Courtesy time clamps to its range
        foreach (hw[i]) begin
            apb(1'b1, HOLD_ADDR, hw[i]);
            apb(1'b0, HOLD_ADDR, 32'h0);
            chk(rd, hx[i]);
        end
        // Interlock route and polarity table
        foreach (rows[i]) begin
            apb(1'b1, CTRL_ADDR, cw(1'b1, rows[i].rt, rows[i].pol, 1'b0,
                RT_OFF, PR_HOLD));
            bar(4'b0000);
            n = act_cnt;
            ticket(8'h03);
            idle(8);
            chk(act_cnt - n, 1);
            chk(32'(phys), 32'(rows[i].held));
            chk(32'(oe), 32'(rows[i].held[1]));
            apb(1'b0, STAT_ADDR, 32'h0);
            chk(32'(rd[ST_LINE_BIT]), 32'(!rows[i].held[1]));
            chk(32'(aux_o), 32'h0);
            bar(4'b0001);
            idle(4);
            chk(32'(phys), 32'(rows[i].free));
        end
        // Trigger edge choice
        apb(1'b1, CTRL_ADDR, cw(1'b0, 3'h1, 1'b0, 1'b0, RT_OFF, PR_HOLD));
        bar(4'b0000);
        n = act_cnt;
        ticket(8'd20);
        idle(5);
        chk(act_cnt - n, 1);
        idle(25);
        chk(act_cnt - n, 1);
        chk(32'(phys), 32'h0);
        apb(1'b1, CTRL_ADDR, cw(1'b1, 3'h1, 1'b0, 1'b0, RT_OFF, PR_HOLD));
        n = act_cnt;
        ticket(8'd20);
        idle(5);
        chk(act_cnt - n, 0);
        idle(25);
        chk(act_cnt - n, 1);
        chk(32'(phys), 32'h1);
        bar(4'b0001);
        // Hold profile with a four second courtesy phase
        apb(1'b1, CTRL_ADDR, cw(1'b0, 3'h0, 1'b0, 1'b1, RT_LAMP, PR_HOLD));
        idle(150);
        bar(4'b0000);
        ticket(8'h03);
        idle(5);
        chk(32'(phys.lamp), 32'h1);
        bar(4'b1100);
        idle(10);
        chk(32'(phys.lamp), 32'h1);
        bar(4'b0001);
        idle(60);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(32'({rd[ST_BUSY_BIT], phys.lamp}), 32'h3);
        idle(40);
        chk(32'(phys.lamp), 32'h0);
        bar(4'b1000);
        idle(10);
        bar(4'b0001);
        idle(10);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(32'({rd[ST_BUSY_BIT], phys.lamp}), 32'h0);
        // Other profiles and the enable
        lt(PR_MOTION, 1'b1, 4'b0010, 1'b0);
        lt(PR_MOTION, 1'b1, 4'b1100, 1'b1);
        lt(PR_STEADY, 1'b1, 4'b0010, 1'b1);
        lt(PR_STEADY, 1'b1, 4'b1100, 1'b1);
        lt(PR_STEADY, 1'b1, 4'b0000, 1'b0);
        lt(PR_FLASH, 1'b0, 4'b1100, 1'b0);
        lt(PR_FLASH, 1'b1, 4'b0010, 1'b1);
        h = 0;
        repeat (16) begin
            @(posedge clk);
            h += int'(phys.lamp === 1'b1);
        end
        chk(h, 8);
        bar(4'b0000);
        idle(5);
        chk(32'(phys.lamp), 32'h0);
        // Reset again in mid-run
        lt(PR_STEADY, 1'b1, 4'b1100, 1'b1);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(1);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(32'(phys), 32'h0);
        results();
    end
endmodule : test_barrier_aux_output_logic
